//--- design/exec_slice.sv
// Register access over Wishbone and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
// Function
// RULE1: Subtract with borrow: file minus W minus notC.
// RULE2: Destination bit zero selects W, else file.
// RULE3: Bank bit zero uses access bank.
// RULE4: File address is instruction low byte.
// RULE5: Nibble swap to destination, flags untouched.
// RULE6: Table read fetches memory byte, two cycles.
// RULE7: Low bits pick pointer keep, inc, dec, preinc.
// RULE8: Table write puts latch at pointer byte.
// RULE9: Zero test skips next instruction as nop.
// RULE10: Skip costs one or two extra cycles.
// RULE11: XOR literal into W, flags N and Z.
// RULE12: XOR W with file to destination.
// RULE13: Subtract carry is not borrow; N, Z.
// RULE14: Decode Q1, read Q2, process Q3, write Q4.
module exec_slice
    import exec_slice_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone classic slave.
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [3:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // Instruction fetch side.
    input  wire logic [15:0] instr_i,
    input  wire logic        instr_valid_i,
    input  wire logic        next_two_word_i,
    output logic             instr_ready_o,
    output logic             skip_o,
    // Data register file.
    output logic      [11:0] file_addr_o,
    input  wire logic [7:0]  file_rdata_i,
    output logic             file_we_o,
    output logic      [7:0]  file_wdata_o,
    // Program memory.
    output logic      [20:0] pm_addr_o,
    output logic             pm_rd_o,
    input  wire logic [7:0]  pm_rdata_i,
    output logic             pm_wr_o,
    output logic      [7:0]  pm_wdata_o,
    output logic      [1:0]  quarter_o
);

    // Register indexes on the bus (word addressed by adr_i[3:2]).
    localparam logic [1:0] R_WORK   = 2'h0;
    localparam logic [1:0] R_STATUS = 2'h1;
    localparam logic [1:0] R_BANK   = 2'h2;
    localparam logic [1:0] R_TPTR   = 2'h3;

    typedef enum logic [2:0] {
        S_IDLE, S_EXEC, S_TBL2, S_SKIP1, S_SKIP2
    } state_e;

    state_e      state_q;
    logic [1:0]  q_q;
    logic [15:0] ir_q;
    logic [7:0]  working_register_q;
    logic [4:0]  status_q;
    logic [3:0]  bank_q;
    logic [20:0] tptr_q;
    logic [7:0]  tlat_q;
    logic [7:0]  opnd_q;
    logic [7:0]  res_q;
    logic [4:0]  flg_q;
    logic [4:0]  flg_mask_q;
    logic        wr_w_q;
    logic        wr_f_q;
    logic        skip_q;
    logic        two_word_q;
    logic        ack_q;
    logic [31:0] dat_q;

    // Opcode decode helpers. Each one compares only the fixed opcode
    // bits, so the destination, bank and modifier fields pass through.
    function automatic logic is_subb(input logic [15:0] i);
        return i[15:10] == OP_SUBB_HI; // RULE1
    endfunction
    function automatic logic is_swap(input logic [15:0] i);
        return i[15:10] == OP_SWAP_HI; // RULE5
    endfunction
    function automatic logic is_xorf(input logic [15:0] i);
        return i[15:10] == OP_XORF_HI; // RULE12
    endfunction
    function automatic logic is_tst(input logic [15:0] i);
        return i[15:9] == OP_TST_HI; // RULE9
    endfunction
    function automatic logic is_xorl(input logic [15:0] i);
        return i[15:8] == OP_XORL_HI; // RULE11
    endfunction
    function automatic logic is_trd(input logic [15:0] i);
        return i[15:2] == OP_TRD_HI; // RULE6
    endfunction
    function automatic logic is_twr(input logic [15:0] i);
        return i[15:2] == OP_TWR_HI; // RULE8
    endfunction

    // Table pointer step for a modifier code.
    function automatic logic [20:0] ptr_step(input logic [20:0] p,
                                             input logic [1:0]  m);
        logic [20:0] r;
        r = p;
        if (m == PTR_POST_INC || m == PTR_PRE_INC) begin
            r = p + 21'h00_0001;
        end else if (m == PTR_POST_DEC) begin
            r = p - 21'h00_0001;
        end
        return r;
    endfunction

    // Banked address: access bank or bank select register.
    logic [11:0] faddr;
    always_comb begin
        if (ir_q[BANK_BIT]) begin
            faddr = {bank_q, ir_q[7:0]}; // RULE3 RULE4
        end else if (ir_q[7:0] < ACCESS_SPLIT) begin
            faddr = {4'h0, ir_q[7:0]}; // RULE3
        end else begin
            faddr = {4'hF, ir_q[7:0]}; // RULE3
        end
    end

    // Subtract with borrow datapath, computed from the latched operand.
    logic [8:0] diff;
    logic [4:0] ldiff;
    logic [7:0] subres;
    always_comb begin
        diff   = {1'b0, opnd_q} - {1'b0, working_register_q}
                 - {8'h00, ~status_q[FLAG_C]}; // RULE1
        ldiff  = {1'b0, opnd_q[3:0]} - {1'b0, working_register_q[3:0]}
                 - {4'h0, ~status_q[FLAG_C]};
        subres = diff[7:0];
    end

    // Quarter phase counter, one instruction cycle is four clocks.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_q <= 2'h0;
        end else begin
            q_q <= q_q + 2'h1; // RULE14
        end
    end

    // Instruction sequencer.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q    <= S_IDLE;
            ir_q       <= 16'h0000;
            two_word_q <= 1'b0;
        end else if (q_q == Q_LAST) begin
            // A table operation or a skip holds the next take back by one
            // or two instruction cycles. The last of those cycles takes
            // the next word itself, so no idle cycle follows it.
            unique case (state_q)
                S_EXEC: begin
                    if (skip_q) begin
                        state_q    <= S_SKIP1; // RULE9 RULE10
                        two_word_q <= next_two_word_i;
                    end else if (is_trd(ir_q) || is_twr(ir_q)) begin
                        state_q <= S_TBL2; // RULE6
                    end else if (instr_valid_i) begin
                        state_q <= S_EXEC;
                        ir_q    <= instr_i;
                    end else begin
                        state_q <= S_IDLE;
                    end
                end
                S_SKIP1: begin
                    if (two_word_q) begin
                        state_q <= S_SKIP2; // RULE10
                    end else if (instr_valid_i) begin
                        state_q <= S_EXEC; // RULE10
                        ir_q    <= instr_i;
                    end else begin
                        state_q <= S_IDLE;
                    end
                end
                S_IDLE, S_TBL2, S_SKIP2: begin
                    if (instr_valid_i) begin
                        state_q <= S_EXEC;
                        ir_q    <= instr_i;
                    end else begin
                        state_q <= S_IDLE;
                    end
                end
            endcase
        end
    end

    // Operand read in Q2, process in Q3.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            opnd_q     <= 8'h00;
            res_q      <= 8'h00;
            flg_q      <= 5'h00;
            flg_mask_q <= 5'h00;
            wr_w_q     <= 1'b0;
            wr_f_q     <= 1'b0;
            skip_q     <= 1'b0;
        end else if (state_q == S_EXEC && q_q == 2'h1) begin
            opnd_q <= is_xorl(ir_q) ? ir_q[7:0] : file_rdata_i; // RULE14
            skip_q <= 1'b0;
        end else if (state_q == S_EXEC && q_q == 2'h2) begin
            flg_mask_q <= 5'h00;
            wr_w_q     <= 1'b0;
            wr_f_q     <= 1'b0;
            if (is_subb(ir_q)) begin
                res_q              <= subres;
                flg_q[FLAG_C]      <= ~diff[8]; // RULE13
                flg_q[FLAG_HC]     <= ~ldiff[4];
                flg_q[FLAG_Z]      <= subres == 8'h00; // RULE13
                flg_q[FLAG_N]      <= subres[7]; // RULE13
                flg_q[FLAG_SW]     <= (opnd_q[7] != working_register_q[7])
                                      && (subres[7] != opnd_q[7]);
                flg_mask_q         <= 5'h1F; // RULE1
                wr_w_q             <= ~ir_q[DEST_BIT]; // RULE2
                wr_f_q             <= ir_q[DEST_BIT]; // RULE2
            end else if (is_swap(ir_q)) begin
                res_q  <= {opnd_q[3:0], opnd_q[7:4]}; // RULE5
                wr_w_q <= ~ir_q[DEST_BIT]; // RULE2
                wr_f_q <= ir_q[DEST_BIT];
            end else if (is_xorf(ir_q) || is_xorl(ir_q)) begin
                res_q         <= working_register_q ^ opnd_q; // RULE11 RULE12
                flg_q[FLAG_Z] <= (working_register_q ^ opnd_q) == 8'h00;
                flg_q[FLAG_N] <= (working_register_q[7] ^ opnd_q[7]);
                flg_mask_q    <= 5'h14; // RULE11 RULE12
                wr_w_q <= is_xorl(ir_q) | ~ir_q[DEST_BIT]; // RULE2
                wr_f_q <= is_xorf(ir_q) & ir_q[DEST_BIT];
            end else if (is_tst(ir_q)) begin
                skip_q <= opnd_q == 8'h00; // RULE9
            end
        end
    end

    // Working register: Q4 writeback or bus write.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            working_register_q <= WORK_RESET;
        end else if (state_q == S_EXEC && q_q == Q_LAST && wr_w_q) begin
            working_register_q <= res_q; // RULE14 RULE2
        end else if (ack_q == 1'b0 && cyc_i && stb_i && we_i
                     && adr_i[3:2] == R_WORK && sel_i[0]) begin
            working_register_q <= dat_i[7:0];
        end
    end

    // Status flags: instruction updates only its own flags. The core's
    // writeback wins over a bus write that falls in the same cycle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_q <= 5'h00;
        end else if (state_q == S_EXEC && q_q == Q_LAST) begin
            status_q <= (status_q & ~flg_mask_q) | (flg_q & flg_mask_q);
        end else if (ack_q == 1'b0 && cyc_i && stb_i && we_i
                     && adr_i[3:2] == R_STATUS && sel_i[0]) begin
            status_q <= dat_i[4:0];
        end
    end

    // Bank select register.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bank_q <= BANK_RESET;
        end else if (ack_q == 1'b0 && cyc_i && stb_i && we_i
                     && adr_i[3:2] == R_BANK && sel_i[0]) begin
            bank_q <= dat_i[3:0];
        end
    end

    // Table pointer and latch. Pre-increment acts in the first cycle,
    // post modifiers after the access in the second cycle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tptr_q <= TPTR_RESET;
            tlat_q <= 8'h00;
        end else if (state_q == S_EXEC && q_q == Q_LAST
                     && (is_trd(ir_q) || is_twr(ir_q))
                     && ir_q[1:0] == PTR_PRE_INC) begin
            tptr_q <= ptr_step(tptr_q, ir_q[1:0]); // RULE7
        end else if (state_q == S_TBL2 && q_q == Q_LAST) begin
            if (is_trd(ir_q)) begin
                tlat_q <= pm_rdata_i; // RULE6
            end
            if (ir_q[1:0] != PTR_PRE_INC) begin
                tptr_q <= ptr_step(tptr_q, ir_q[1:0]); // RULE7
            end
        end else if (ack_q == 1'b0 && cyc_i && stb_i && we_i
                     && adr_i[3:2] == R_TPTR) begin
            if (sel_i[0]) tptr_q[7:0]   <= dat_i[7:0];
            if (sel_i[1]) tptr_q[15:8]  <= dat_i[15:8];
            if (sel_i[2]) tptr_q[20:16] <= dat_i[20:16];
            if (sel_i[3]) tlat_q        <= dat_i[31:24];
        end
    end

    // Bus acknowledge and read data, one wait state.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            ack_q <= cyc_i && stb_i && !ack_q;
            unique case (adr_i[3:2])
                R_WORK:   dat_q <= {24'h00_0000, working_register_q};
                R_STATUS: dat_q <= {27'h000_0000, status_q};
                R_BANK:   dat_q <= {28'h000_0000, bank_q};
                R_TPTR:   dat_q <= {tlat_q, 3'h0, tptr_q};
            endcase
        end
    end

    // Output drive. The take strobe also opens in the last cycle of a
    // table operation or a skip, so the next word follows without a gap.
    always_comb begin
        ack_o         = ack_q;
        dat_o         = dat_q;
        quarter_o     = q_q;
        file_addr_o   = faddr;
        file_wdata_o  = res_q;
        file_we_o     = state_q == S_EXEC && q_q == Q_LAST && wr_f_q;
        instr_ready_o = q_q == Q_LAST
                        && (state_q == S_IDLE || state_q == S_TBL2
                            || state_q == S_SKIP2
                            || (state_q == S_SKIP1 && !two_word_q)
                            || (state_q == S_EXEC && !skip_q
                                && !is_trd(ir_q) && !is_twr(ir_q)));
        skip_o        = state_q == S_SKIP1 || state_q == S_SKIP2; // RULE10
        pm_addr_o     = tptr_q; // RULE6 RULE8
        pm_rd_o       = state_q == S_TBL2 && is_trd(ir_q) && q_q == 2'h1;
        pm_wr_o       = state_q == S_TBL2 && is_twr(ir_q)
                        && q_q == Q_LAST; // RULE8
        pm_wdata_o    = tlat_q;
    end

endmodule

//--- design/exec_slice_pkg.sv
package exec_slice_pkg;

    // Opcode match values on the upper instruction bits, masked as noted.
    localparam logic [5:0] OP_SUBB_HI   = 6'h16;   // Bits 15:10 = 0101 10.
    localparam logic [5:0] OP_SWAP_HI   = 6'h0E;   // Bits 15:10 = 0011 10.
    localparam logic [5:0] OP_XORF_HI   = 6'h06;   // Bits 15:10 = 0001 10.
    localparam logic [6:0] OP_TST_HI    = 7'h33;   // Bits 15:9 = 0110 011.
    localparam logic [7:0] OP_XORL_HI   = 8'h0A;   // Bits 15:8 = 0000 1010.
    localparam logic [13:0] OP_TRD_HI   = 14'h0002; // Bits 15:2 = ...0010.
    localparam logic [13:0] OP_TWR_HI   = 14'h0003; // Bits 15:2 = ...0011.

    // Pointer modifier codes.
    localparam logic [1:0] PTR_NONE = 2'h0;
    localparam logic [1:0] PTR_POST_INC = 2'h1;
    localparam logic [1:0] PTR_POST_DEC = 2'h2;
    localparam logic [1:0] PTR_PRE_INC  = 2'h3;

    // Field positions inside the instruction word.
    localparam int DEST_BIT = 9;
    localparam int BANK_BIT = 8;

    // Reset values.
    localparam logic [7:0]  WORK_RESET = 8'h00;
    localparam logic [3:0]  BANK_RESET = 4'h0;
    localparam logic [20:0] TPTR_RESET = 21'h00_0000;

    // Access bank split: addresses below this map to bank 0, others to 15.
    localparam logic [7:0] ACCESS_SPLIT = 8'h80;

    // Index of the last quarter phase in an instruction cycle.
    localparam logic [1:0] Q_LAST = 2'h3;

    // Status flag positions in the status byte.
    localparam int FLAG_C  = 0;
    localparam int FLAG_HC = 1;
    localparam int FLAG_Z  = 2;
    localparam int FLAG_SW = 3;
    localparam int FLAG_N  = 4;

endpackage

//--- testbench/exec_slice_asserts.sv
`timescale 1ns/1ns
module exec_slice_asserts
    import exec_slice_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        ack_o,
    input wire logic [15:0] instr_i,
    input wire logic        instr_valid_i,
    input wire logic        instr_ready_o,
    input wire logic        skip_o,
    input wire logic [11:0] file_addr_o,
    input wire logic [7:0]  file_rdata_i,
    input wire logic        file_we_o,
    input wire logic [7:0]  file_wdata_o,
    input wire logic        pm_rd_o,
    input wire logic        pm_wr_o,
    input wire logic [1:0]  quarter_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // An instruction word is taken at the last quarter.
    sequence s_take;
        instr_valid_i && instr_ready_o && quarter_o == Q_LAST;
    endsequence
    sequence s_take_rd;
        s_take ##0 instr_i[15:2] == OP_TRD_HI;
    endsequence
    sequence s_take_wt;
        s_take ##0 instr_i[15:2] == OP_TWR_HI;
    endsequence
    property p_ack;
        cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o;
    endproperty
    property p_quarter;
        !rst_i && quarter_o != Q_LAST |=> quarter_o == $past(quarter_o) + 2'h1;
    endproperty
    property p_wr_q4;
        file_we_o |-> quarter_o == 2'h3;
    endproperty
    property p_table_read_op;
        s_take_rd |=> !pm_rd_o [*5] ##1 pm_rd_o ##1 !pm_rd_o;
    endproperty
    property p_table_write_op;
        s_take_wt |=> !pm_wr_o [*7] ##1 pm_wr_o;
    endproperty
    property p_swap;
        s_take ##0 instr_i[15:10] == OP_SWAP_HI && instr_i[DEST_BIT] |-> ##4
        file_we_o && file_wdata_o == {file_rdata_i[3:0], file_rdata_i[7:4]}
        && file_addr_o[7:0] == $past(instr_i[7:0], 4);
    endproperty
    property p_dest_w;
        s_take ##0 instr_i[15:10] == OP_XORF_HI && !instr_i[DEST_BIT]
        |=> !file_we_o [*4];
    endproperty
    property p_skip;
        skip_o |-> !file_we_o && !pm_rd_o && !pm_wr_o
                   && (quarter_o == Q_LAST || !instr_ready_o);
    endproperty
    a_ack:     assert property (p_ack) else $error("ack timing wrong");
    a_quarter: assert property (p_quarter) else $error("quarter step");
    a_wr_q4:   assert property (p_wr_q4) else $error("write off Q4");
    a_table_read_op:   assert property (p_table_read_op) else $error("table read");
    a_table_write_op:   assert property (p_table_write_op) else $error("table write");
    a_swap:    assert property (p_swap) else $error("swap result");
    a_dest_w:  assert property (p_dest_w) else $error("file written");
    a_skip:    assert property (p_skip) else $error("skip not idle");
endmodule
bind exec_slice exec_slice_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .instr_i(instr_i),
    .instr_valid_i(instr_valid_i), .instr_ready_o(instr_ready_o),
    .skip_o(skip_o), .file_addr_o(file_addr_o), .file_rdata_i(file_rdata_i),
    .file_we_o(file_we_o), .file_wdata_o(file_wdata_o), .pm_rd_o(pm_rd_o),
    .pm_wr_o(pm_wr_o), .quarter_o(quarter_o));

//--- testbench/exec_slice_mem.sv
`timescale 1ns/1ns
module exec_slice_mem (
    input  wire logic        clk_i,
    input  wire logic [11:0] file_addr_i,
    input  wire logic        file_we_i,
    input  wire logic [7:0]  file_wdata_i,
    output logic      [7:0]  file_rdata_o,
    input  wire logic [20:0] pm_addr_i,
    input  wire logic        pm_wr_i,
    input  wire logic [7:0]  pm_wdata_i,
    output logic      [7:0]  pm_rdata_o
);
    logic [7:0] fmem [4096];
    logic [7:0] pmem [256];
    // Reads follow the address at once, as an array of latches would.
    assign file_rdata_o = fmem[file_addr_i];
    assign pm_rdata_o   = pmem[pm_addr_i[7:0]];
    // Writes land at the edge that closes the strobe cycle.
    always @(posedge clk_i) begin
        if (file_we_i) begin
            fmem[file_addr_i] <= file_wdata_i;
        end
        if (pm_wr_i) begin
            pmem[pm_addr_i[7:0]] <= pm_wdata_i;
        end
    end
endmodule

//--- testbench/exec_slice_tb_top.sv
`timescale 1ns/1ns
module exec_slice_tb_top
    import exec_slice_pkg::*;
;
    logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
    logic [3:0]  adr_i = 0, sel_i = 0;
    logic [31:0] dat_i = 0, dat_o, q;
    logic [15:0] instr_i = 0, ins;
    logic        instr_valid_i = 0, next_two_word_i = 0, ack_o, instr_ready_o;
    logic        skip_o, file_we_o, pm_rd_o, pm_wr_o, d, a;
    logic [11:0] file_addr_o, ad;
    logic [7:0]  file_rdata_i, file_wdata_o, pm_rdata_i, pm_wdata_o;
    logic [7:0]  w, fv, f, k, lt, ew, ef;
    logic [20:0] pm_addr_o, p, ea, ep;
    logic [1:0]  quarter_o, md;
    logic [4:0]  st;
    logic [3:0]  bk;
    logic [12:0] r;
    int          error_cnt = 0, checks_done = 0, cyc_cnt = 0, op, n, en;
    exec_slice dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
        .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .instr_i(instr_i),
        .instr_valid_i(instr_valid_i), .next_two_word_i(next_two_word_i),
        .instr_ready_o(instr_ready_o), .skip_o(skip_o),
        .file_addr_o(file_addr_o), .file_rdata_i(file_rdata_i),
        .file_we_o(file_we_o), .file_wdata_o(file_wdata_o),
        .pm_addr_o(pm_addr_o), .pm_rd_o(pm_rd_o), .pm_rdata_i(pm_rdata_i),
        .pm_wr_o(pm_wr_o), .pm_wdata_o(pm_wdata_o), .quarter_o(quarter_o));
    exec_slice_mem mem (.clk_i(clk_i), .file_addr_i(file_addr_o),
        .file_we_i(file_we_o), .file_wdata_i(file_wdata_o),
        .file_rdata_o(file_rdata_i), .pm_addr_i(pm_addr_o),
        .pm_wr_i(pm_wr_o), .pm_wdata_i(pm_wdata_o), .pm_rdata_o(pm_rdata_i));
    // Free-running clock; a cycle ceiling cuts a hang short.
    always #25 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            error_cnt++;
            results();
        end
    end
    task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic results();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // One classic cycle, held until ack is sampled high.
    task automatic wb(logic wr, logic [3:0] ad4, logic [31:0] wd);
        cyc_i <= 1;
        stb_i <= 1;
        we_i <= wr;
        adr_i <= ad4;
        sel_i <= 4'hf;
        dat_i <= wd;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        q = dat_o;
        cyc_i <= 0;
        stb_i <= 0;
        @(posedge clk_i);
    endtask
    // Hands one word over, then counts clocks until the next take point.
    task automatic run(logic [15:0] iw);
        instr_i <= iw;
        instr_valid_i <= 1;
        do @(posedge clk_i); while (!(quarter_o == 2'h3 && instr_ready_o));
        instr_valid_i <= 0;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (!(quarter_o == 2'h3 && instr_ready_o));
    endtask
    function automatic logic [11:0] fa(logic ab, logic [7:0] fr, logic [3:0] b);
        if (ab) return {b, fr};
        return (fr < ACCESS_SPLIT) ? {4'h0, fr} : {4'hf, fr};
    endfunction
    // Returns the status byte and the result for one operation.
    function automatic logic [12:0] model(int o, logic [7:0] wv, logic [7:0] x,
                                          logic [7:0] kv, logic [4:0] s0);
        logic [8:0] s;
        logic [4:0] h;
        logic [7:0] rr;
        logic [4:0] fl;
        fl = s0;
        case (o)
            0: begin
                s = {1'b0, x} + {1'b0, ~wv} + 9'(s0[FLAG_C]);
                h = {1'b0, x[3:0]} + {1'b0, ~wv[3:0]} + 5'(s0[FLAG_C]);
                rr = s[7:0];
                fl[FLAG_C] = s[8];
                fl[FLAG_HC] = h[4];
                fl[FLAG_SW] = (x[7] != wv[7]) && (rr[7] != x[7]);
            end
            1: rr = {x[3:0], x[7:4]};
            2: rr = wv ^ x;
            3: rr = wv ^ kv;
            default: rr = x;
        endcase
        if (o == 0 || o == 2 || o == 3) begin
            fl[FLAG_N] = rr[7];
            fl[FLAG_Z] = (rr == 8'h00);
        end
        return {fl, rr};
    endfunction
    initial begin
        void'($urandom(12994));
        repeat (5) @(posedge clk_i);
        rst_i <= 0;
        for (int i = 0; i < 16; i += 4) begin
            wb(0, 4'(i), 32'h0000_0000);
            check("reset word", q, 32'h0000_0000);
        end
        for (int i = 0; i < 80; i++) begin
            op = $urandom_range(0, 4);
            {w, f, k, lt} = $urandom;
            fv = (i % 4 == 0) ? 8'h00 : 8'($urandom);
            {st, bk, d, a} = 11'($urandom);
            wb(1, 4'h0, {24'h0000_00, w});
            wb(1, 4'h4, {27'h000_0000, st});
            wb(1, 4'h8, {28'h000_0000, bk});
            ad = fa(a, f, bk);
            mem.fmem[ad] = fv;
            case (op)
                0: ins = {OP_SUBB_HI, d, a, f};
                1: ins = {OP_SWAP_HI, d, a, f};
                2: ins = {OP_XORF_HI, d, a, f};
                3: ins = {OP_XORL_HI, k};
                default: ins = {OP_TST_HI, a, f};
            endcase
            next_two_word_i <= lt[0];
            r = model(op, w, fv, k, st);
            ew = (op == 3 || (op < 3 && !d)) ? r[7:0] : w;
            ef = (op < 3 && d) ? r[7:0] : fv;
            en = (op == 4 && fv == 8'h00) ? (lt[0] ? 12 : 8) : 4;
            run(ins);
            check("cycles", n, en);
            wb(0, 4'h0, 32'h0000_0000);
            check("w", q[7:0], ew);
            wb(0, 4'h4, 32'h0000_0000);
            check("status", q[4:0], r[12:8]);
            check("file", mem.fmem[ad], ef);
        end
        for (int m = 0; m < 8; m++) begin
            md = 2'(m);
            {p, lt} = {21'($urandom), 8'($urandom)};
            wb(1, 4'hc, {lt, 3'h0, p});
            ea = (md == PTR_PRE_INC) ? p + 21'h1 : p;
            ep = (md == PTR_NONE) ? p : (md == PTR_POST_DEC) ? p - 21'h1
                 : p + 21'h1;
            k = 8'($urandom);
            mem.pmem[ea[7:0]] = k;
            run(m > 3 ? {OP_TWR_HI, md} : {OP_TRD_HI, md});
            check("table cycles", n, 8);
            wb(0, 4'hc, 32'h0000_0000);
            check("pointer", q[20:0], ep);
            check("latch", q[31:24], m > 3 ? lt : k);
            check("pm byte", mem.pmem[ea[7:0]], m > 3 ? lt : k);
        end
        results();
    end
endmodule
